// ===== rtl/flash_id_pkg.sv
// Constants, types and register layout for the identifier-space readout
//
// Behaviour
// - Identifier mode: offset 00 gives maker word, 01 gives part word (top/bottom).
// - Identifier mode: offset 03 gives the silicon revision word.
// - Identifier mode: offset 05 gives the live burst configuration contents.
// - Identifier mode: offset 80 gives the protection-area lock word.
// - Identifier mode: offsets 81..88 give unique number then user OTP words.
// - Identifier mode: offset 02 gives addressed block's protection state, codes 0000 to 0003.
package flash_id_pkg;

  localparam int ADDR_W = 21;
  localparam int WORD_W = 16;
  localparam int OFF_W = 8;
  localparam int WA_W = 9;

  ////////////////////////////////////////////////////////////////////////////
  // Bank-relative identifier offsets
  localparam logic [OFF_W-1:0] OFF_MAKER = 8'h00;
  localparam logic [OFF_W-1:0] OFF_PART = 8'h01;
  localparam logic [OFF_W-1:0] OFF_BLKPROT = 8'h02;
  localparam logic [OFF_W-1:0] OFF_REV = 8'h03;
  localparam logic [OFF_W-1:0] OFF_BCR = 8'h05;
  localparam logic [OFF_W-1:0] OFF_LOCK = 8'h80;
  localparam logic [OFF_W-1:0] OFF_PR_FIRST = 8'h81;
  localparam logic [OFF_W-1:0] OFF_PR_LAST = 8'h88;
  localparam logic [OFF_W-1:0] OFF_OTP_FIRST = 8'h85;

  ////////////////////////////////////////////////////////////////////////////
  // Write-port addresses
  localparam logic [WA_W-1:0] WA_BCR = 9'h005;
  localparam logic [WA_W-1:0] WA_LOCK = 9'h080;
  localparam logic [WA_W-1:0] WA_BLK_BASE = 9'h100;
  localparam int WA_BLK_SEL = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Protection codes and reset values
  localparam logic [1:0] PROT_UNLOCKED = 2'h0;
  localparam logic [1:0] PROT_LOCKED = 2'h1;
  localparam logic [1:0] PROT_DOWN_UNLOCKED = 2'h2;
  localparam logic [1:0] PROT_DOWN_LOCKED = 2'h3;
  localparam int PROT_LOCK_BIT = 0;
  localparam int PROT_DOWN_BIT = 1;
  localparam logic [WORD_W-1:0] LOCK_RESET = 16'h0006;
  localparam logic [WORD_W-1:0] LOCK_MASK = 16'h0006;
  localparam int LOCK_OTP_BIT = 1;
  localparam logic [WORD_W-1:0] BCR_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [WORD_W-1:0] WORD_ERASED = 16'hffff;

  ////////////////////////////////////////////////////////////////////////////
  // Block geometry
  localparam int PARAM_BLOCKS = 8;
  localparam int MAIN_BLOCKS = 63;
  localparam int BLOCKS = 71;
  localparam int BLK_W = 7;
  localparam int PARAM_SHIFT = 12;
  localparam int MAIN_SHIFT = 15;
  localparam int PR_WORDS = 8;
  localparam int PR_AW = 3;
  localparam int UID_WORDS = 4;

  typedef struct packed {
    logic stb;
    logic [WA_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } wr_req_s;

endpackage

// ===== rtl/flash_id_readout.sv
// Identifier-space read decode with protection, lock and burst-config state
`timescale 1ns/10ps
`default_nettype none
module flash_id_readout
  import flash_id_pkg::*;
#(
  parameter logic [WORD_W-1:0] MAKER_CODE = 16'h00a5, // Arbitrary value
  parameter logic [WORD_W-1:0] PART_TOP = 16'h5a10, // Arbitrary value
  parameter logic [WORD_W-1:0] PART_BOTTOM = 16'h5a11, // Arbitrary value
  parameter logic [WORD_W-1:0] SILICON_REV = 16'h0001, // Arbitrary value
  parameter logic [63:0] UNIQUE_ID = 64'h0123456789abcdef, // Arbitrary value
  parameter bit TOP_LAYOUT = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic id_mode,
  input wire logic [ADDR_W-1:0] adr_pin,
  input wire logic latch_n_pin,
  input wire logic rd_stb,
  input wire wr_req_s wr,
  output logic [WORD_W-1:0] rd_data
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Parameter blocks are 4 KWord, main blocks 32 KWord
  function automatic logic [BLK_W-1:0] blk_of(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-MAIN_SHIFT-1:0] hi;
    logic [MAIN_SHIFT-PARAM_SHIFT-1:0] lo;
    hi = a[ADDR_W-1:MAIN_SHIFT];
    lo = a[MAIN_SHIFT-1:PARAM_SHIFT];
    if (TOP_LAYOUT) begin
      if (&hi) begin
        blk_of = BLK_W'(MAIN_BLOCKS) + BLK_W'(lo);
      end else begin
        blk_of = BLK_W'(hi);
      end
    end else begin
      if (hi == '0) begin
        blk_of = BLK_W'(lo);
      end else begin
        blk_of = BLK_W'(hi) + BLK_W'(PARAM_BLOCKS - 1);
      end
    end
  endfunction

  function automatic logic in_pr(input logic [OFF_W-1:0] o);
    in_pr = (o >= OFF_PR_FIRST) && (o <= OFF_PR_LAST);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and address latch

  logic [ADDR_W-1:0] adr_q1_ff, adr_q2_ff, lat_addr_ff, nxt_lat_addr;
  logic latch_q1_ff, latch_q2_ff, latch_q3_ff;
  logic latch_rise;

  // Address is taken on the rising edge of the latch input
  assign latch_rise = latch_q2_ff & ~latch_q3_ff;

  always_comb begin
    nxt_lat_addr = lat_addr_ff;
    if (latch_rise) begin
      nxt_lat_addr = adr_q2_ff;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      adr_q1_ff <= '0;
      adr_q2_ff <= '0;
      latch_q1_ff <= 1'b1;
      latch_q2_ff <= 1'b1;
      latch_q3_ff <= 1'b1;
      lat_addr_ff <= '0;
    end else begin
      adr_q1_ff <= adr_pin;
      adr_q2_ff <= adr_q1_ff;
      latch_q1_ff <= latch_n_pin;
      latch_q2_ff <= latch_q1_ff;
      latch_q3_ff <= latch_q2_ff;
      lat_addr_ff <= nxt_lat_addr;
    end
  end

  logic [OFF_W-1:0] lat_off;
  logic [BLK_W-1:0] lat_blk;
  assign lat_off = lat_addr_ff[OFF_W-1:0];
  assign lat_blk = blk_of(lat_addr_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration, lock word and block protection state

  logic [WORD_W-1:0] bcr_ff, nxt_bcr, lock_ff, nxt_lock;
  logic [1:0] prot_ff [BLOCKS];
  logic [1:0] nxt_prot [BLOCKS];
  logic [BLK_W-1:0] wr_blk;
  logic wr_is_blk, pr_wr_en;
  logic [PR_AW-1:0] pr_wr_addr;

  assign wr_blk = wr.addr[BLK_W-1:0];
  assign wr_is_blk = wr.addr[WA_BLK_SEL] && (wr_blk < BLK_W'(BLOCKS));

  always_comb begin
    nxt_bcr = bcr_ff;
    nxt_lock = lock_ff;
    nxt_prot = prot_ff;
    if (wr.stb) begin
      if (wr.addr == WA_BCR) begin
        nxt_bcr = wr.data;
      end
      // Lock bits program one way only, like the cells they mirror
      if (wr.addr == WA_LOCK) begin
        nxt_lock = lock_ff & (wr.data | ~LOCK_MASK);
      end
      if (wr_is_blk) begin
        if (wr.data[PROT_DOWN_BIT] || prot_ff[wr_blk][PROT_DOWN_BIT]) begin
          // Lock-down also locks and cannot be undone short of reset
          nxt_prot[wr_blk] = PROT_DOWN_LOCKED;
        end else begin
          nxt_prot[wr_blk] = {1'b0, wr.data[PROT_LOCK_BIT]};
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bcr_ff <= BCR_RESET;
      lock_ff <= LOCK_RESET;
      for (int i = 0; i < BLOCKS; i++) begin
        prot_ff[i] <= PROT_LOCKED;
      end
    end else begin
      bcr_ff <= nxt_bcr;
      lock_ff <= nxt_lock;
      prot_ff <= nxt_prot;
    end
  end

  // Unique number words are never writable; user words only while unlocked
  assign pr_wr_en = wr.stb && (wr.addr[WA_W-1:OFF_W] == '0) &&
                    (wr.addr[OFF_W-1:0] >= OFF_OTP_FIRST) &&
                    (wr.addr[OFF_W-1:0] <= OFF_PR_LAST) &&
                    lock_ff[LOCK_OTP_BIT];
  assign pr_wr_addr = PR_AW'(wr.addr[OFF_W-1:0] - OFF_PR_FIRST);

  ////////////////////////////////////////////////////////////////////////////
  // Protection-area words

  logic [PR_AW-1:0] pr_rd_addr, pr_prog_addr;
  logic [WORD_W-1:0] pr_q, pr_wr_data;

  // Read port follows the latched address, so a read needs two cycles' notice
  assign pr_rd_addr = PR_AW'(lat_off - OFF_PR_FIRST);
  assign pr_prog_addr = pr_wr_addr;
  assign pr_wr_data = wr.data;

  pr_word_mem #(
    .WIDTH(WORD_W),
    .DEPTH(PR_WORDS),
    .AW(PR_AW),
    .ID_WORDS(UID_WORDS),
    .UID(UNIQUE_ID)
  ) u_pr_mem (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(pr_wr_en),
    .wr_addr(pr_prog_addr),
    .wr_data(pr_wr_data),
    .rd_addr(pr_rd_addr),
    .rd_data(pr_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read decode

  logic [WORD_W-1:0] rd_data_ff, nxt_rd_data;

  always_comb begin
    nxt_rd_data = rd_data_ff;
    if (rd_stb) begin
      nxt_rd_data = WORD_ZERO;
      if (id_mode) begin
        if (lat_off == OFF_MAKER) begin
          nxt_rd_data = MAKER_CODE;
        end else if (lat_off == OFF_PART) begin
          nxt_rd_data = TOP_LAYOUT ? PART_TOP : PART_BOTTOM;
        end else if (lat_off == OFF_BLKPROT) begin
          nxt_rd_data = {{(WORD_W-2){1'b0}}, prot_ff[lat_blk]};
        end else if (lat_off == OFF_REV) begin
          nxt_rd_data = SILICON_REV;
        end else if (lat_off == OFF_BCR) begin
          nxt_rd_data = bcr_ff;
        end else if (lat_off == OFF_LOCK) begin
          nxt_rd_data = lock_ff;
        end else if (in_pr(lat_off)) begin
          nxt_rd_data = pr_q;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data_ff <= WORD_ZERO;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data = rd_data_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  logic id_rd;
  assign id_rd = rd_stb && id_mode;

  sequence s_rd(logic [OFF_W-1:0] o);
    id_rd && (lat_off == o);
  endsequence

  property p_maker;
    @(posedge clk_sys) disable iff (rst)
      s_rd(OFF_MAKER) |=> rd_data == MAKER_CODE;
  endproperty
  a_maker: assert property (p_maker) else $error("maker word wrong");

  property p_part;
    @(posedge clk_sys) disable iff (rst)
      s_rd(OFF_PART) |=> rd_data == (TOP_LAYOUT ? PART_TOP : PART_BOTTOM);
  endproperty
  a_part: assert property (p_part) else $error("part word wrong");

  property p_rev;
    @(posedge clk_sys) disable iff (rst)
      s_rd(OFF_REV) |=> rd_data == SILICON_REV;
  endproperty
  a_rev: assert property (p_rev) else $error("revision word wrong");

  sequence s_bcr_wr;
    wr.stb && (wr.addr == WA_BCR);
  endsequence

  property p_bcr;
    @(posedge clk_sys) disable iff (rst)
      s_rd(OFF_BCR) |=> rd_data == $past(bcr_ff);
  endproperty
  a_bcr: assert property (p_bcr) else $error("burst config readback wrong");

  // Readback alone would also pass if writes were dropped, so the store is judged too
  property p_bcr_wr;
    logic [WORD_W-1:0] v;
    @(posedge clk_sys) disable iff (rst)
      (s_bcr_wr, v = wr.data) |=> bcr_ff == v;
  endproperty
  a_bcr_wr: assert property (p_bcr_wr) else $error("burst config write lost");

  property p_lock;
    @(posedge clk_sys) disable iff (rst)
      s_rd(OFF_LOCK) |=> (rd_data == $past(lock_ff)) && ((rd_data & ~LOCK_MASK) == '0);
  endproperty
  a_lock: assert property (p_lock) else $error("lock word wrong");

  // Memory read lags the latch by a cycle, so only settled addresses are judged
  property p_pr;
    @(posedge clk_sys) disable iff (rst)
      (id_rd && in_pr(lat_off) && !latch_rise && $stable(lat_addr_ff)) |=>
        rd_data == $past(pr_q);
  endproperty
  a_pr: assert property (p_pr) else $error("protection word wrong");

  property p_prot;
    @(posedge clk_sys) disable iff (rst)
      s_rd(OFF_BLKPROT) |=>
        (rd_data[WORD_W-1:2] == '0) && (rd_data[1:0] == $past(prot_ff[lat_blk]));
  endproperty
  a_prot: assert property (p_prot) else $error("protection state wrong");

  logic [BLK_W-1:0] ld_blk_ff;
  always_ff @(posedge clk_sys) begin
    ld_blk_ff <= wr_blk;
  end

  sequence s_ld_wr;
    wr.stb && wr_is_blk && wr.data[PROT_DOWN_BIT];
  endsequence

  property p_lockdown;
    @(posedge clk_sys) disable iff (rst)
      s_ld_wr |=> prot_ff[ld_blk_ff] == PROT_DOWN_LOCKED;
  endproperty
  a_lockdown: assert property (p_lockdown) else $error("lock-down not held");

  property p_unmapped;
    @(posedge clk_sys) disable iff (rst)
      (rd_stb && !id_mode) |=> rd_data == WORD_ZERO;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("read outside mode not zero");

endmodule
`default_nettype wire

// ===== rtl/pr_word_mem.sv
// Small memory holding the unique number and user OTP words
`timescale 1ns/10ps
`default_nettype none
module pr_word_mem
  import flash_id_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int AW = 3,
  parameter int ID_WORDS = 4,
  parameter logic [63:0] UID = 64'h0123456789abcdef
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] rd_ff;

  // Reset restores factory content; a real part keeps it in cells
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (i < ID_WORDS) begin
          mem_ff[i] <= UID[i*WIDTH +: WIDTH];
        end else begin
          mem_ff[i] <= WORD_ERASED[WIDTH-1:0];
        end
      end
      rd_ff <= '0;
    end else begin
      if (wr_en) begin
        mem_ff[wr_addr] <= wr_data;
      end
      rd_ff <= mem_ff[rd_addr];
    end
  end

  assign rd_data = rd_ff;

endmodule
`default_nettype wire

// ===== testbench/host_model.sv
// Host controller model driving the address pins and the address latch
`timescale 1ns/10ps
`default_nettype none
module host_model
  import flash_id_pkg::*;
(
  input wire logic clk_sys,
  output logic [ADDR_W-1:0] adr_pin,
  output logic latch_n_pin
);
  initial begin
    adr_pin = '0;
    latch_n_pin = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Address held 2 cycles before and 3 after the latch rise, then released
  task automatic send_addr(input logic [ADDR_W-1:0] a);
    @(posedge clk_sys);
    adr_pin <= a;
    latch_n_pin <= 1'b0;
    repeat (2) @(posedge clk_sys);
    latch_n_pin <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // Inverted value so a late capture cannot pass by luck
    adr_pin <= ~a;
    repeat (2) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the identifier-space readout
`timescale 1ns/10ps
`default_nettype none
`define CHK(name, exp, act) \
  begin \
    compares++; \
    if ((act) !== (exp)) begin \
      err_count++; \
      $display("wrong value %s: expected %h, seen %h", name, exp, act); \
    end \
  end
module testbench
  import flash_id_pkg::*;
;
  localparam logic [WORD_W-1:0] MK = 16'h0c3a; // Arbitrary value
  localparam logic [WORD_W-1:0] PT = 16'h7e21; // Arbitrary value
  localparam logic [WORD_W-1:0] PB = 16'h7e22; // Arbitrary value
  localparam logic [WORD_W-1:0] REV = 16'h0042; // Arbitrary value
  localparam logic [63:0] UID = 64'h1122334455667788; // Arbitrary value
  logic clk_sys;
  logic rst;
  logic id_mode;
  logic rd_stb;
  logic latch_n_pin;
  logic [ADDR_W-1:0] adr_pin;
  wr_req_s wr;
  logic [WORD_W-1:0] rd_data;
  logic [WORD_W-1:0] rd_data_bot;
  int err_count = 0;
  int compares = 0;

  flash_id_readout #(.MAKER_CODE(MK), .PART_TOP(PT), .PART_BOTTOM(PB), .SILICON_REV(REV),
    .UNIQUE_ID(UID), .TOP_LAYOUT(1'b1)) u_flash_id_readout (.clk_sys(clk_sys), .rst(rst),
    .id_mode(id_mode), .adr_pin(adr_pin), .latch_n_pin(latch_n_pin), .rd_stb(rd_stb),
    .wr(wr), .rd_data(rd_data));
  // Bottom-layout copy shares every input, so the other part word is seen too
  flash_id_readout #(.MAKER_CODE(MK), .PART_TOP(PT), .PART_BOTTOM(PB), .SILICON_REV(REV),
    .UNIQUE_ID(UID), .TOP_LAYOUT(1'b0)) u_flash_id_readout_bot (.clk_sys(clk_sys), .rst(rst),
    .id_mode(id_mode), .adr_pin(adr_pin), .latch_n_pin(latch_n_pin), .rd_stb(rd_stb),
    .wr(wr), .rd_data(rd_data_bot));
  host_model u_host_model (.clk_sys(clk_sys), .adr_pin(adr_pin), .latch_n_pin(latch_n_pin));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] e, input string n);
    u_host_model.send_addr(a);
    @(posedge clk_sys);
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1;
    `CHK(n, e, rd_data)
  endtask
  task automatic wr_do(input logic [WA_W-1:0] a, input logic [WORD_W-1:0] d);
    @(posedge clk_sys);
    wr <= '{stb: 1'b1, addr: a, data: d};
    @(posedge clk_sys);
    wr.stb <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_ident();
    rd_chk(21'h000000, MK, "maker");
    rd_chk(21'h100001, PT, "part in upper bank");
    `CHK("part bottom layout", PB, rd_data_bot)
    rd_chk(21'h000003, REV, "revision");
    rd_chk(21'h000004, 16'h0000, "unmapped 04");
    @(posedge clk_sys);
    id_mode <= 1'b0;
    rd_chk(21'h000000, 16'h0000, "maker outside mode");
    @(posedge clk_sys);
    id_mode <= 1'b1;
  endtask
  task automatic t_burst();
    wr_do(WA_BCR, 16'ha5c3);
    rd_chk(21'h000005, 16'ha5c3, "burst config");
    wr_do(WA_BCR, 16'h5a3c);
    rd_chk(21'h000005, 16'h5a3c, "burst config rewrite");
  endtask
  task automatic t_otp();
    for (int i = 0; i < 4; i++) begin
      rd_chk(ADDR_W'(8'h81 + i), UID[16*i +: 16], "unique word");
      rd_chk(ADDR_W'(8'h85 + i), 16'hffff, "blank otp word");
    end
    wr_do(9'h081, 16'h0000);
    rd_chk(21'h000081, UID[15:0], "unique word after write");
    wr_do(9'h088, 16'h1234);
    rd_chk(21'h000088, 16'h1234, "otp word 88");
    rd_chk(21'h000080, 16'h0006, "lock word reset");
    wr_do(WA_LOCK, 16'hfffd);
    rd_chk(21'h000080, 16'h0004, "lock word set");
    wr_do(9'h085, 16'h5555);
    rd_chk(21'h000085, 16'hffff, "otp refused when locked");
  endtask
  task automatic t_block();
    rd_chk(21'h000002, 16'h0001, "block 0 reset");
    wr_do(WA_BLK_BASE, 16'h0000);
    rd_chk(21'h000002, 16'h0000, "block 0 unlocked");
    wr_do(WA_BLK_BASE, 16'h0001);
    rd_chk(21'h000002, 16'h0001, "block 0 locked");
    wr_do(WA_BLK_BASE, 16'h0002);
    rd_chk(21'h000002, 16'h0003, "block 0 lock-down");
    wr_do(WA_BLK_BASE, 16'h0000);
    rd_chk(21'h000002, 16'h0003, "lock-down sticky");
    wr_do(9'h146, 16'h0000);
    rd_chk(21'h1ff002, 16'h0000, "block 70 unlocked");
    rd_chk(21'h028002, 16'h0001, "block 5 untouched");
  endtask
  // Mid-run reset must clear lock-down and every written state
  task automatic t_reset();
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(21'h000002, 16'h0001, "block 0 after reset");
    rd_chk(21'h000080, 16'h0006, "lock word after reset");
    rd_chk(21'h000005, 16'h0000, "burst config after reset");
    rd_chk(21'h000088, 16'hffff, "otp after reset");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    id_mode = 1'b1;
    rd_stb = 1'b0;
    wr = '0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    t_ident();
    t_burst();
    t_otp();
    t_block();
    t_reset();
    give_verdict();
  end
  // Run needs about 350 cycles; the limit leaves wide margin
  initial begin
    #100000;
    err_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
